// *** power_mode_clock_select.sv ***
/*
  power-mode and clock-source control: three special function registers,
  low-power entry and wake, oscillator power control, clock switch request
  and timer tick enable.
  assumes oscillator stable flags, calibration busy and the glitch-free mux
  acknowledge come from the analog side, synchronous to mclk.
*/
`timescale 1ns/1ps
`default_nettype none
module power_mode_clock_select
  import pwr_clk_pkg::*;
(
  // clock and reset
  input  wire logic       mclk,
  input  wire logic       rst,
  // special function register port
  input  wire logic [7:0] sfr_addr,
  input  wire logic       sfr_wr,
  input  wire logic [7:0] sfr_wdata,
  input  wire logic       sfr_rd,
  output var  logic [7:0] sfr_rdata,
  // reset cause, sampled when the system reset is held
  input  wire logic       por_event,
  input  wire logic       ext_event,
  input  wire logic       wdt_event,
  // interrupt and wake inputs
  input  wire logic       irq_pending,
  input  wire logic       wake_event,
  // oscillator status
  input  wire logic       xosc_stable,
  input  wire logic       rcosc_stable,
  input  wire logic       cal_busy,
  input  wire logic       switch_ack,
  // oscillator and clock controls
  output var  logic       xosc_pd,
  output var  logic       rcosc_pd,
  output var  logic       sys_clk_sel,
  output var  logic       slow_clock_source_select,
  output var  logic       calibration_enable,
  output var  logic       timer_tick,
  // power state
  output var  logic [1:0] power_mode,
  output var  logic       sleeping
);
  import pwr_clk_pkg::*;

  logic [5:0] power_mode_control_spare_q;      // unused storage bits
  logic [1:0] mode_q;            // requested power mode
  logic       pd_q;              // power-down of unselected oscillator
  logic       pd_pend_q;         // deferred power-down write pending
  logic       pd_val_q;          // deferred value
  logic       caldis_q;          // calibration disable
  logic [1:0] cause_q;           // last reset cause
  logic       slow_sel_q;        // 32 kHz source select
  logic       osc_sel_q;         // requested system clock
  logic       run_q;             // running clock (speed flag)
  logic [2:0] tick_q;            // timer tick rate
  logic [6:0] tick_cnt_q;        // tick divider, 7 bits reach rate 111
  seq_t       st_q;              // sequencer state
  logic       wr_power_mode_control;
  logic       wr_sleep;
  logic       wr_clk;
  logic       idle_go;
  logic       deep_wake;
  logic       sel_stable;
  logic       new_stable;

  // register write decode
  assign wr_power_mode_control  = sfr_wr && (sfr_addr == ADDR_PWR_CTRL);
  assign wr_sleep = sfr_wr && (sfr_addr == ADDR_SLEEP_CTL);
  assign wr_clk   = sfr_wr && (sfr_addr == ADDR_CLK_CTL);
  // idle request only accepted with no enabled interrupt pending
  assign idle_go  = wr_power_mode_control && sfr_wdata[POWER_MODE_CONTROL_IDLE_BIT]
                    && !irq_pending && (st_q == ST_RUN); // [RULE1] [RULE2]
  // leaving the two deepest modes drops non-retained bits
  assign deep_wake = (st_q == ST_SLEEP) && wake_event && mode_q[1];
  // stability of requested source
  assign sel_stable = osc_sel_q ? rcosc_stable : xosc_stable;
  assign new_stable = sel_stable && (run_q != osc_sel_q);

  // power-mode sequencer
  always_ff @(posedge mclk)
  begin
    if (rst)
      st_q <= ST_RUN;
    else
      case (st_q)
        ST_RUN:
        begin
          // a refused idle leaves the device active
          if (idle_go && mode_q != PM_ACTIVE) // [RULE2]
            st_q <= ST_ENTER;
        end
        ST_ENTER:
        begin
          // hold off until calibration completes, whatever the calibration disable bit
          if (!cal_busy)
            st_q <= ST_SLEEP;
        end
        ST_SLEEP:
        begin
          if (wake_event) // [RULE23]
            st_q <= ST_RUN;
        end
        default:
          st_q <= ST_RUN;
      endcase
  end

  // power control spare storage; idle bit is not stored
  always_ff @(posedge mclk)
  begin
    if (rst)
      power_mode_control_spare_q <= RST_POWER_MODE_CONTROL_SPARE; // [RULE4]
    else if (wr_power_mode_control)
      power_mode_control_spare_q <= sfr_wdata[7:POWER_MODE_CONTROL_SPARE_LO]; // [RULE4]
  end

  // power mode field, cleared by a wake
  always_ff @(posedge mclk)
  begin
    if (rst)
      mode_q <= PM_ACTIVE; // [RULE13]
    else if (st_q == ST_SLEEP && wake_event)
      mode_q <= PM_ACTIVE; // [RULE23]
    else if (wr_sleep)
      mode_q <= sfr_wdata[1:0]; // [RULE13]
  end

  // oscillator power-down, deferred over a running calibration
  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      pd_q      <= RST_PD; // [RULE11]
      pd_pend_q <= 1'b0;
      pd_val_q  <= RST_PD;
    end
    else if (wr_sleep && cal_busy)
    begin
      pd_pend_q <= 1'b1; // [RULE12]
      pd_val_q  <= sfr_wdata[SLP_PD_BIT];
    end
    else if (wr_sleep)
    begin
      pd_q      <= sfr_wdata[SLP_PD_BIT];
      pd_pend_q <= 1'b0;
    end
    else if (pd_pend_q && !cal_busy)
    begin
      pd_q      <= pd_val_q; // [RULE12]
      pd_pend_q <= 1'b0;
    end
  end

  // calibration disable, lost in the deepest modes
  always_ff @(posedge mclk)
  begin
    if (rst || deep_wake)
      caldis_q <= RST_CALDIS; // [RULE5] [RULE7]
    else if (wr_sleep)
      caldis_q <= sfr_wdata[SLP_CALDIS_BIT]; // [RULE5]
  end

  // last reset cause, caught while reset is held
  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      if (wdt_event)
        cause_q <= CAUSE_WDT; // [RULE10]
      else if (ext_event)
        cause_q <= CAUSE_EXT; // [RULE10]
      else if (por_event)
        cause_q <= CAUSE_POR; // [RULE10]
    end
  end

  // clock control fields
  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      slow_sel_q <= RST_SLOW_SEL; // [RULE14]
      osc_sel_q  <= RST_OSC_SEL; // [RULE17]
      tick_q     <= RST_TICK; // [RULE20]
    end
    else
    begin
      if (deep_wake)
        slow_sel_q <= RST_SLOW_SEL; // [RULE16]
      else if (wr_clk)
        slow_sel_q <= sfr_wdata[CLK_SLOW_BIT]; // [RULE14]
      if (wr_clk)
      begin
        osc_sel_q <= sfr_wdata[CLK_OSC_BIT]; // [RULE17]
        tick_q    <= sfr_wdata[5:CLK_TICK_LO]; // [RULE20]
      end
    end
  end

  // running clock follows request once stable and mux confirms
  always_ff @(posedge mclk)
  begin
    if (rst)
      run_q <= RST_OSC_SEL;
    else if (new_stable && switch_ack) // [RULE18] [RULE24]
      run_q <= osc_sel_q; // [RULE22]
  end

  // timer tick divider: 2^rate base cycles per tick
  always_ff @(posedge mclk)
  begin
    if (rst)
      tick_cnt_q <= 7'h00;
    else
      tick_cnt_q <= tick_cnt_q + 7'h01;
  end

  // oscillator power outputs; a selected oscillator is powered except in sleep, where both are powered down
  always_comb
  begin
    if (st_q == ST_SLEEP)
    begin
      xosc_pd  = 1'b1;
      rcosc_pd = 1'b1;
    end
    else
    begin
      // requested and running sources stay up during a switch
      xosc_pd  = pd_q && osc_sel_q && run_q; // [RULE11] [RULE19]
      rcosc_pd = pd_q && !osc_sel_q && !run_q; // [RULE11] [RULE19]
    end
  end

  // clock and status outputs
  always_comb
  begin
    sys_clk_sel              = run_q; // [RULE24]
    slow_clock_source_select = slow_sel_q;
    // disable honoured only while running on the RC oscillator
    calibration_enable = !(caldis_q && run_q); // [RULE6]
    power_mode = mode_q;
    sleeping   = (st_q == ST_SLEEP);
    // limitation: software keeps rate within clock, not checked here
    case (tick_q)
      3'h0:    timer_tick = 1'b1;
      3'h1:    timer_tick = tick_cnt_q[0];
      3'h2:    timer_tick = &tick_cnt_q[1:0];
      3'h3:    timer_tick = &tick_cnt_q[2:0];
      3'h4:    timer_tick = &tick_cnt_q[3:0];
      3'h5:    timer_tick = &tick_cnt_q[4:0];
      3'h6:    timer_tick = &tick_cnt_q[5:0];
      default: timer_tick = &tick_cnt_q[6:0];
    endcase
  end

  // read data register
  always_ff @(posedge mclk)
  begin
    if (rst)
      sfr_rdata <= 8'h00;
    else if (sfr_rd)
      case (sfr_addr)
        ADDR_PWR_CTRL:
          sfr_rdata <= {power_mode_control_spare_q, 2'b00}; // [RULE1] [RULE4]
        ADDR_SLEEP_CTL:
          sfr_rdata <= {caldis_q, xosc_stable && !xosc_pd,
                        rcosc_stable && !rcosc_pd, cause_q,
                        pd_q, mode_q}; // [RULE8] [RULE9]
        ADDR_CLK_CTL:
          sfr_rdata <= {slow_sel_q, osc_sel_q, tick_q,
                        2'b00, run_q}; // [RULE22]
        default:
          sfr_rdata <= 8'h00;
      endcase
  end

  // idle bit never stored: power control read never shows bit 0
  property p_idle_reads_zero;
    @(posedge mclk) disable iff (rst)
    $past(sfr_rd) && $past(sfr_addr) == ADDR_PWR_CTRL |-> !sfr_rdata[0];
  endproperty
  a_idle_reads_zero: assert property (p_idle_reads_zero) // [RULE1]
    else $error("idle bit read nonzero");

  property p_refuse;
    @(posedge mclk) disable iff (rst)
    (st_q == ST_RUN) && wr_power_mode_control && sfr_wdata[0] && irq_pending
      |=> st_q == ST_RUN;
  endproperty
  a_refuse: assert property (p_refuse) // [RULE2]
    else $error("entry not refused with pending interrupt");

  property p_enter;
    @(posedge mclk) disable iff (rst)
    (st_q == ST_RUN) && wr_power_mode_control && sfr_wdata[POWER_MODE_CONTROL_IDLE_BIT]
      && !irq_pending && mode_q != PM_ACTIVE |=> st_q == ST_ENTER;
  endproperty
  a_enter: assert property (p_enter) // [RULE1]
    else $error("idle request did not start entry");

  property p_wake_clears;
    @(posedge mclk) disable iff (rst)
    st_q == ST_SLEEP && wake_event |=> mode_q == PM_ACTIVE && !sleeping;
  endproperty
  a_wake_clears: assert property (p_wake_clears) // [RULE23]
    else $error("wake did not clear mode");

  property p_deep_restore;
    @(posedge mclk) disable iff (rst)
    deep_wake |=> slow_sel_q && !caldis_q;
  endproperty
  a_deep_restore: assert property (p_deep_restore) // [RULE7] [RULE16]
    else $error("non-retained bits kept after deep sleep");

  property p_pd_defer;
    @(posedge mclk) disable iff (rst)
    wr_sleep && cal_busy |=> pd_q == $past(pd_q);
  endproperty
  a_pd_defer: assert property (p_pd_defer) // [RULE12]
    else $error("power-down updated during calibration");

  property p_switch_stable;
    @(posedge mclk) disable iff (rst)
    // stability judged at the edge that launched the change
    $changed(run_q) |-> (run_q ? $past(rcosc_stable) : $past(xosc_stable));
  endproperty
  a_switch_stable: assert property (p_switch_stable) // [RULE18]
    else $error("clock switched to unstable source");

  property p_sel_powered;
    @(posedge mclk) disable iff (rst)
    !sleeping |-> (osc_sel_q ? !rcosc_pd : !xosc_pd);
  endproperty
  a_sel_powered: assert property (p_sel_powered) // [RULE19]
    else $error("selected oscillator left powered down");

  property p_caldis_rc;
    @(posedge mclk) disable iff (rst)
    !calibration_enable |-> run_q && caldis_q;
  endproperty
  a_caldis_rc: assert property (p_caldis_rc) // [RULE6]
    else $error("calibration disabled off the RC clock");
endmodule
`default_nettype wire

// *** pwr_clk_pkg.sv ***
/*
  power-mode and clock-source control constants: special function register
  addresses, field positions, reset values and mode encodings.
  assumes one 200 MHz core clock and an 8-bit special function register port.
*/
// Function
// [RULE1] idle request starts selected low-power entry
// [RULE2] pending enabled interrupt refuses low-power entry
// [RULE3] software disables interrupts before idle request
// [RULE4] power control bits 7:2 stored, bit1 zero
// [RULE5] bit 7 disables slow RC calibration
// [RULE6] calibration disable effective only on RC clock
// [RULE7] calibration disable cleared by deep sleeps
// [RULE8] bit 6 shows crystal powered and stable
// [RULE9] bit 5 shows fast RC powered and stable
// [RULE10] bits 4:3 hold last reset cause
// [RULE11] bit 2 powers down unselected oscillator
// [RULE12] power-down write deferred during calibration
// [RULE13] bits 1:0 select power mode, reset zero
// [RULE14] bit 7 selects slow clock source
// [RULE15] slow source changed only on RC clock; not enforced, any clock control write sets it unless a deep-sleep wake falls in the same cycle
// [RULE16] slow source select restored by deep sleeps
// [RULE17] bit 6 selects system clock, reset one
// [RULE18] new source applied only once stable
// [RULE19] selecting powered-down oscillator powers it up
// [RULE20] bits 5:3 set timer tick rate
// [RULE21] tick rate never faster than system clock; not enforced, any written rate is used
// [RULE22] bit 0 reports running clock speed
// [RULE23] wake event returns to active, clears mode
// [RULE24] glitch-free clock changeover on safe edges
`default_nettype none
package pwr_clk_pkg;
  // register addresses
  localparam logic [7:0] ADDR_PWR_CTRL  = 8'h87;
  localparam logic [7:0] ADDR_SLEEP_CTL = 8'hbe;
  localparam logic [7:0] ADDR_CLK_CTL   = 8'hc6;
  // sleep control fields
  localparam int SLP_CALDIS_BIT = 7;
  localparam int SLP_XSTB_BIT   = 6;
  localparam int SLP_RCSTB_BIT  = 5;
  localparam int SLP_RST_LO     = 3;
  localparam int SLP_PD_BIT     = 2;
  // clock control fields
  localparam int CLK_SLOW_BIT   = 7;
  localparam int CLK_OSC_BIT    = 6;
  localparam int CLK_TICK_LO    = 3;
  // power control fields
  localparam int POWER_MODE_CONTROL_IDLE_BIT  = 0;
  localparam int POWER_MODE_CONTROL_SPARE_LO  = 2;
  // reset values
  localparam logic [5:0] RST_POWER_MODE_CONTROL_SPARE = 6'h00;
  localparam logic [2:0] RST_TICK       = 3'h1;
  localparam logic       RST_SLOW_SEL   = 1'b1;
  localparam logic       RST_OSC_SEL    = 1'b1;
  localparam logic       RST_PD         = 1'b1;
  localparam logic       RST_CALDIS     = 1'b0;
  // reset causes
  localparam logic [1:0] CAUSE_POR = 2'h0;
  localparam logic [1:0] CAUSE_EXT = 2'h1;
  localparam logic [1:0] CAUSE_WDT = 2'h2;
  // switch handshake timeout in cycles
  localparam int SWITCH_WAIT = 4;
  // power modes
  typedef enum logic [1:0]
  {
    PM_ACTIVE = 2'b00,
    PM_LIGHT  = 2'b01,
    PM_DEEP   = 2'b10,
    PM_DEEPEST = 2'b11
  } pmode_t;
  // sequencer states
  typedef enum logic [1:0]
  {
    ST_RUN   = 2'b00,
    ST_ENTER = 2'b01,
    ST_SLEEP = 2'b10
  } seq_t;
endpackage
`default_nettype wire

// *** tb_power_mode_clock_select.sv ***
/*
  bench for power_mode_clock_select: register reads, sleep entry and
  wake, clock switching and tick rate, all compared with a bench model.
  assumes the bench drives every oscillator status input itself.
*/
`timescale 1ns/1ps
`default_nettype none
module tb;
  import pwr_clk_pkg::*;
  // design ports
  logic        mclk, rst, sfr_wr, sfr_rd;
  logic [7:0]  sfr_addr, sfr_wdata, sfr_rdata;
  logic        por_event, ext_event, wdt_event, irq_pending, wake_event;
  logic        xosc_stable, rcosc_stable, cal_busy, switch_ack;
  logic        xosc_pd, rcosc_pd, sys_clk_sel, slow_clock_source_select;
  logic        calibration_enable, timer_tick, sleeping;
  logic [1:0]  power_mode;
  // model state, one int per field
  int          fails, num_checks, pcs, cald, cause, pd, mode, slow;
  int          sel, run, tck, n;
  logic [31:0] seed;
  int          q[$];

  power_mode_clock_select power_mode_clock_select_i (
    .mclk(mclk), .rst(rst), .sfr_addr(sfr_addr), .sfr_wr(sfr_wr),
    .sfr_wdata(sfr_wdata), .sfr_rd(sfr_rd), .sfr_rdata(sfr_rdata),
    .por_event(por_event), .ext_event(ext_event), .wdt_event(wdt_event),
    .irq_pending(irq_pending), .wake_event(wake_event),
    .xosc_stable(xosc_stable), .rcosc_stable(rcosc_stable),
    .cal_busy(cal_busy), .switch_ack(switch_ack), .xosc_pd(xosc_pd),
    .rcosc_pd(rcosc_pd), .sys_clk_sel(sys_clk_sel),
    .slow_clock_source_select(slow_clock_source_select),
    .calibration_enable(calibration_enable), .timer_tick(timer_tick),
    .power_mode(power_mode), .sleeping(sleeping));

  // 200 MHz clock
  initial
  begin
    mclk = 1'b0;
    forever #2.5 mclk = ~mclk;
  end

  // xorshift source, fixed start
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction

  // sleep register as the model expects it
  function automatic logic [7:0] ex_slp();
    logic xp, rp;
    xp = pd[0] & sel[0] & run[0];
    rp = pd[0] & ~sel[0] & ~run[0];
    return {cald[0], xosc_stable & ~xp, rcosc_stable & ~rp, cause[1:0],
            pd[0], mode[1:0]};
  endfunction

  // clock register as the model expects it, bits 2:1 zero
  function automatic logic [7:0] ex_clk();
    return {slow[0], sel[0], tck[2:0], 2'h0, run[0]};
  endfunction

  task automatic wrap_up();
    if (fails == 0 && num_checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    num_checks++;
    if (got !== exp)
    begin
      fails++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // one write strobe, then an idle cycle so strobes never merge
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge mclk);
    sfr_addr = a;
    sfr_wdata = d;
    sfr_wr = 1'b1;
    @(negedge mclk);
    sfr_wr = 1'b0;
  endtask

  // read data stands until the next read, sampled a cycle late
  task automatic rchk(input logic [7:0] a, input logic [7:0] e);
    @(negedge mclk);
    sfr_addr = a;
    sfr_rd = 1'b1;
    @(negedge mclk);
    sfr_rd = 1'b0;
    @(negedge mclk);
    chk(sfr_rdata, e);
  endtask

  // bounded wait on sleeping (s=0) or running source (s=1)
  task automatic wt(input int s, input logic v);
    int k;
    k = 0;
    while ((s ? sys_clk_sel : sleeping) !== v && k < 20)
    begin
      @(negedge mclk);
      k++;
    end
  endtask

  // reset with one cause level held, model back to reset values
  task automatic do_rst(input int c);
    @(negedge mclk);
    rst = 1'b1;
    por_event = (c == 0);
    ext_event = (c == 1);
    wdt_event = (c == 2);
    repeat (12) @(negedge mclk);
    rst = 1'b0;
    cause = c;
    pcs = 0;
    cald = 0;
    pd = 1;
    mode = 0;
    slow = 1;
    sel = 1;
    run = 1;
    tck = 1;
  endtask

  // hang guard, far beyond the few thousand cycles the run needs
  initial
  begin
    repeat (20000) @(posedge mclk);
    fails++;
    wrap_up();
  end

  initial
  begin
    {rst, sfr_wr, sfr_rd, sfr_addr, sfr_wdata} = {3'b100, 16'h0000};
    {por_event, ext_event, wdt_event, irq_pending, wake_event} = 5'h00;
    {xosc_stable, rcosc_stable, cal_busy, switch_ack} = 4'b0101;
    fails = 0;
    num_checks = 0;
    seed = 32'd72726;
    // every reset cause, watchdog first
    for (int c = 2; c >= 0; c--)
    begin
      do_rst(c);
      rchk(ADDR_SLEEP_CTL, ex_slp());
      rchk(ADDR_CLK_CTL, ex_clk());
      rchk(ADDR_PWR_CTRL, 8'h00);
      chk(8'(slow_clock_source_select), 8'(slow));
    end
    // spare storage bits with random data, idle bit kept clear
    repeat (4)
    begin
      q.push_back(rnd() & 32'hfe);
      wr(ADDR_PWR_CTRL, 8'(q[$]));
      pcs = q.pop_front() & 8'hfc;
      rchk(ADDR_PWR_CTRL, 8'(pcs));
    end
    rchk(8'h55, 8'h00);
    // pending interrupt refuses entry
    wr(ADDR_SLEEP_CTL, 8'h05);
    mode = 1;
    irq_pending = 1'b1;
    wr(ADDR_PWR_CTRL, 8'h01);
    pcs = 0;
    repeat (10) @(negedge mclk);
    chk(8'(sleeping), 8'h00);
    irq_pending = 1'b0;
    // each low-power mode, with fields that deep sleeps must restore
    for (int m = 1; m < 4; m++)
    begin
      wr(ADDR_SLEEP_CTL, 8'(8'h84 | m));
      cald = 1;
      mode = m;
      wr(ADDR_CLK_CTL, 8'h48);
      slow = 0;
      chk(8'(calibration_enable), 8'h00);
      chk(8'(slow_clock_source_select), 8'(slow));
      rchk(ADDR_SLEEP_CTL, ex_slp());
      wr(ADDR_PWR_CTRL, 8'h01);
      wt(0, 1'b1);
      chk(8'(sleeping), 8'h01);
      wake_event = 1'b1;
      @(negedge mclk);
      wake_event = 1'b0;
      wt(0, 1'b0);
      chk({6'h00, power_mode}, 8'h00);
      mode = 0;
      if (m > 1)
      begin
        cald = 0;
        slow = 1;
      end
      chk(8'(slow_clock_source_select), 8'(slow));
      rchk(ADDR_SLEEP_CTL, ex_slp());
      rchk(ADDR_CLK_CTL, ex_clk());
      rchk(ADDR_PWR_CTRL, 8'(pcs));
    end
    // power-down write held back while calibrating
    wr(ADDR_CLK_CTL, 8'hc8);
    slow = 1;
    cal_busy = 1'b1;
    wr(ADDR_SLEEP_CTL, 8'h00);
    cald = 0;
    rchk(ADDR_SLEEP_CTL, ex_slp());
    cal_busy = 1'b0;
    pd = 0;
    repeat (2) @(negedge mclk);
    rchk(ADDR_SLEEP_CTL, ex_slp());
    chk(8'(xosc_pd), 8'h00);
    wr(ADDR_SLEEP_CTL, 8'h04);
    pd = 1;
    chk(8'(xosc_pd), 8'h01);
    // switch to the crystal, unstable first, then no safe edge
    wr(ADDR_CLK_CTL, 8'h88);
    sel = 0;
    chk(8'(xosc_pd), 8'h00);
    repeat (4) @(negedge mclk);
    chk(8'(sys_clk_sel), 8'h01);
    rchk(ADDR_CLK_CTL, ex_clk());
    switch_ack = 1'b0;
    xosc_stable = 1'b1;
    repeat (2) @(negedge mclk);
    chk(8'(sys_clk_sel), 8'h01);
    switch_ack = 1'b1;
    wt(1, 1'b0);
    run = 0;
    chk(8'(sys_clk_sel), 8'h00);
    chk(8'(rcosc_pd), 8'h01);
    rchk(ADDR_SLEEP_CTL, ex_slp());
    rchk(ADDR_CLK_CTL, ex_clk());
    // every tick rate, all legal on the crystal
    for (int r = 0; r < 8; r++)
    begin
      wr(ADDR_CLK_CTL, 8'(8'h80 | (r << 3)));
      tck = r;
      n = 0;
      repeat (256)
      begin
        @(negedge mclk);
        if (timer_tick === 1'b1)
          n++;
      end
      chk(8'(n >= (256 >> r) - 1 && n <= (256 >> r) + 1), 8'h01);
    end
    rchk(ADDR_CLK_CTL, ex_clk());
    // disable has no effect while the crystal runs
    wr(ADDR_SLEEP_CTL, 8'h84);
    cald = 1;
    chk(8'(calibration_enable), 8'h01);
    // idle request with the active mode selected stays awake
    wr(ADDR_PWR_CTRL, 8'h01);
    repeat (4) @(negedge mclk);
    chk(8'(sleeping), 8'h00);
    rchk(ADDR_PWR_CTRL, 8'h00);
    wrap_up();
  end
endmodule
`default_nettype wire
